// [rtl/bbrb_pkg.sv]
// constants and carrier types for the battery-backed register bank
package bbrb_pkg;
   localparam logic [31:0] BASE_ADDR = 32'h0000_A400;
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_TEST_A = 8'h04;
   localparam logic [7:0] OFF_CLK_EN = 8'h08;
   localparam logic [7:0] OFF_TEST_B = 8'h10;
   localparam logic [7:0] OFF_TEST_C = 8'h14;
   localparam logic [7:0] OFF_ALT_FN = 8'h18;
   localparam logic [7:0] OFF_TEST_D = 8'h1C;
   localparam int BIT_BAT_RST = 7;
   localparam int BIT_WATCHDOG = 5;
   localparam int BIT_XTAL = 0;
   localparam logic RST_BAT_RST = 1'b1;
   localparam logic RST_WATCHDOG = 1'b0;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } reg_req_t;
endpackage : bbrb_pkg

// [rtl/bbrb_sync2.sv]
// two flip-flop synchroniser for single-bit inputs
`timescale 1ns/1ps
module bbrb_sync2 (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // data
   input wire logic d,
   output logic q
);
   logic meta_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : bbrb_sync2

// [rtl/battery_backed_register_bank.sv]
// battery-backed register bank with status flags and event interrupt
`timescale 1ns/1ps
module battery_backed_register_bank (
   // clock and battery reset
   input wire logic core_clk,
   input wire logic rst_b,
   // register interface
   input wire bbrb_pkg::reg_req_t req,
   output logic [31:0] rdata,
   output logic rvalid,
   output logic hit,
   // events and status
   input wire logic watchdog_event,
   input wire logic slow_crystal_detect,
   output logic power_fail_event_irq,
   // control words to the clock and pin logic
   output logic [31:0] slow_clock_enable_control,
   output logic [31:0] alternate_function_standby_control
);
   // battery reset release
   logic rst_meta_r;
   logic rst_sync_r;

   // synchronised inputs and watchdog edge detect
   logic wd_sync;
   logic xtal_sync;
   logic wd_prev_r;

   // status flags
   logic bat_rst_r;
   logic bat_rst_nxt;
   logic wd_flag_r;
   logic wd_flag_nxt;

   // control and test storage
   logic [31:0] clk_en_r;
   logic [31:0] alt_fn_r;
   logic [31:0] test_r [4];

   // read path
   logic [31:0] rdata_r;
   logic rvalid_r;
   logic [31:0] rd_mux;
   logic [7:0] status_word;

   // release of the battery reset, asserted asynchronously
   // released in step with core_clk so no flop sees the edge inside its aperture
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // watchdog event and crystal detect come from other domains
   bbrb_sync2 u_watchdog_sync (
      .clk(core_clk),
      .rst_b(rst_sync_r),
      .d(watchdog_event),
      .q(wd_sync)
   );

   // crystal presence, shown read-only at status bit 0
   bbrb_sync2 u_xtal_sync (
      .clk(core_clk),
      .rst_b(rst_sync_r),
      .d(slow_crystal_detect),
      .q(xtal_sync)
   );

   // full 32-bit match; the bank has no alias elsewhere in the space
   function automatic logic sel(input logic [31:0] a, input logic [7:0] off);
      sel = (a == bbrb_pkg::BASE_ADDR + {24'h00_0000, off});
   endfunction : sel

   wire sel_status = sel(req.addr, bbrb_pkg::OFF_STATUS);
   wire sel_clk_en = sel(req.addr, bbrb_pkg::OFF_CLK_EN);
   wire sel_alt_fn = sel(req.addr, bbrb_pkg::OFF_ALT_FN);
   wire sel_test_a = sel(req.addr, bbrb_pkg::OFF_TEST_A);
   wire sel_test_b = sel(req.addr, bbrb_pkg::OFF_TEST_B);
   wire sel_test_c = sel(req.addr, bbrb_pkg::OFF_TEST_C);
   wire sel_test_d = sel(req.addr, bbrb_pkg::OFF_TEST_D);
   // hit covers every mapped offset, test registers included
   wire any_sel = sel_status | sel_clk_en | sel_alt_fn | sel_test_a | sel_test_b
                  | sel_test_c | sel_test_d;
   // write strobes per register
   wire wr_status = req.wr & sel_status;
   wire wr_clk_en = req.wr & sel_clk_en;
   wire wr_alt_fn = req.wr & sel_alt_fn;
   // test register strobes, one bit per register
   wire [3:0] test_sel = {sel_test_d, sel_test_c, sel_test_b, sel_test_a};
   // edge, not level: a watchdog held high must not set the flag again after a clear
   wire wd_rise = wd_sync & ~wd_prev_r;

   // one status bit under write-one-to-clear
   function automatic logic w1c(input logic cur, input logic wr_hit, input logic one);
      w1c = cur & ~(wr_hit & one);
   endfunction : w1c

   // write-one-to-clear; a watchdog event in the clearing cycle wins
   assign bat_rst_nxt = w1c(bat_rst_r, wr_status, req.wdata[bbrb_pkg::BIT_BAT_RST]);
   assign wd_flag_nxt = wd_rise |
                        w1c(wd_flag_r, wr_status, req.wdata[bbrb_pkg::BIT_WATCHDOG]);

   // reserved bits stay zero
   assign status_word = {bat_rst_r, 1'b0, wd_flag_r, 4'h0, xtal_sync};
   wire [31:0] status_rd = {24'h00_0000, status_word};

   // read selection; an address outside the map gives zero
   assign rd_mux = sel_status ? status_rd :
                   sel_clk_en ? clk_en_r :
                   sel_alt_fn ? alt_fn_r :
                   sel_test_a ? test_r[0] :
                   sel_test_b ? test_r[1] :
                   sel_test_c ? test_r[2] :
                   sel_test_d ? test_r[3] : bbrb_pkg::RST_WORD;

   // battery reset flag; only the battery reset sets it
   always_ff @(posedge core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         bat_rst_r <= bbrb_pkg::RST_BAT_RST;
      end else begin
         bat_rst_r <= bat_rst_nxt;
      end
   end

   // watchdog flag; nothing from the standby side resets it
   always_ff @(posedge core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         wd_flag_r <= bbrb_pkg::RST_WATCHDOG;
      end else begin
         wd_flag_r <= wd_flag_nxt;
      end
   end

   // idles low like the pin, so no false event after reset
   always_ff @(posedge core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         wd_prev_r <= 1'b0;
      end else begin
         wd_prev_r <= wd_sync;
      end
   end

   // full-word writes only; there are no byte lanes
   // clock enable control word
   always_ff @(posedge core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         clk_en_r <= bbrb_pkg::RST_WORD;
      end else if (wr_clk_en) begin
         clk_en_r <= req.wdata;
      end
   end

   // standby control word
   always_ff @(posedge core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         alt_fn_r <= bbrb_pkg::RST_WORD;
      end else if (wr_alt_fn) begin
         alt_fn_r <= req.wdata;
      end
   end

   // test registers keep what is written; nothing else reads them
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_test
         always_ff @(posedge core_clk or negedge rst_sync_r) begin
            if (!rst_sync_r) begin
               test_r[gi] <= bbrb_pkg::RST_WORD;
            end else if (req.wr && test_sel[gi]) begin
               test_r[gi] <= req.wdata;
            end
         end
      end
   endgenerate

   // one answer per read strobe; reads may run back to back
   // read answer one cycle after the request
   always_ff @(posedge core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= req.rd;
      end
   end

   // zero outside a read so a stale word never shows; unmapped reads give zero
   always_ff @(posedge core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rdata_r <= bbrb_pkg::RST_WORD;
      end else begin
         rdata_r <= req.rd ? rd_mux : bbrb_pkg::RST_WORD;
      end
   end

   // outputs
   assign rdata = rdata_r;
   assign rvalid = rvalid_r;
   assign hit = any_sel;
   // a level while either flag stands; firmware clears it through the flags
   assign power_fail_event_irq = bat_rst_r | wd_flag_r;

   // control words straight from their flops
   assign slow_clock_enable_control = clk_en_r;
   assign alternate_function_standby_control = alt_fn_r;
endmodule : battery_backed_register_bank

// [test/ec_core_model.sv]
// controller core model issuing register cycles
`timescale 1ns/1ps
module host_core_model (
   // clock
   input wire logic core_clk,
   // register interface
   output bbrb_pkg::reg_req_t req,
   input wire logic [31:0] rdata
);
   initial req = '0;
   // one word per call; released lines show inverted values, not the old ones
   task automatic xfer(input logic w, input logic [7:0] o, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge core_clk) #1;
      req = '{~w, w, bbrb_pkg::BASE_ADDR + 32'(o), wd};
      @(posedge core_clk) #1;
      rd = rdata;
      req = '{1'b0, 1'b0, ~req.addr, ~req.wdata};
   endtask : xfer
endmodule : host_core_model

// [test/bbrb_sva.sv]
// assertions on the register bank ports
`timescale 1ns/1ps
module bbrb_sva (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // watched ports
   input wire bbrb_pkg::reg_req_t req,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic hit,
   input wire logic watchdog_event,
   input wire logic power_fail_event_irq,
   input wire logic [31:0] slow_clock_enable_control
);
   localparam logic [31:0] A_ST = bbrb_pkg::BASE_ADDR;
   localparam logic [31:0] A_CE = bbrb_pkg::BASE_ADDR + 32'(bbrb_pkg::OFF_CLK_EN);
   wire ce_wr = req.wr && req.addr == A_CE;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_read_answer: assert property (req.rd |=> rvalid) else $error("no answer");
   a_unmapped_zero: assert property (rvalid && !$past(hit) |-> rdata == '0)
      else $error("unmapped read not zero");
   a_reserved_zero: assert property (rvalid && $past(req.addr) == A_ST
      |-> (rdata & 32'hFFFF_FF5E) == '0) else $error("reserved bits set");
   a_irq_drop: assert property ($fell(power_fail_event_irq)
      |-> $past(req.wr) && $past(req.addr) == A_ST) else $error("irq fell alone");
   a_irq_rise: assert property ($rose(power_fail_event_irq)
      |-> $past(watchdog_event, 2)) else $error("irq rose alone");
   a_ce_write: assert property (ce_wr
      |=> slow_clock_enable_control == $past(req.wdata)) else $error("ce not written");
   a_ce_hold: assert property (!ce_wr |=> $stable(slow_clock_enable_control))
      else $error("ce changed");
   a_status_hit: assert property (req.addr == A_ST |-> hit) else $error("no hit");
endmodule : bbrb_sva
bind battery_backed_register_bank bbrb_sva i_bbrb_sva (.core_clk(core_clk), .rst_b(rst_b),
   .req(req), .rdata(rdata), .rvalid(rvalid), .hit(hit), .watchdog_event(watchdog_event),
   .power_fail_event_irq(power_fail_event_irq),
   .slow_clock_enable_control(slow_clock_enable_control));

// [test/battery_backed_register_bank_tb.sv]
// self-checking bench for the battery-backed register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module battery_backed_register_bank_tb;
   logic core_clk = 0, rst_b = 0, wd = 0, xtal = 1, irq;
   logic [31:0] ce, alt, d;
   logic [7:0] offs [7] = '{8'h08, 8'h18, 8'h04, 8'h10, 8'h14, 8'h1C, 8'h0C};
   bbrb_pkg::reg_req_t req;
   int n_errors = 0, compares = 0, cyc = 0;
   battery_backed_register_bank i_battery_backed_register_bank (.core_clk(core_clk),
      .rst_b(rst_b), .req(req), .rdata(d), .rvalid(), .hit(), .watchdog_event(wd),
      .slow_crystal_detect(xtal), .power_fail_event_irq(irq),
      .slow_clock_enable_control(ce), .alternate_function_standby_control(alt));
   host_core_model i_host_core_model (.core_clk(core_clk), .req(req), .rdata(d));
   initial forever #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic st(input logic [7:0] e);
      logic [31:0] r;
      i_host_core_model.xfer(1'b0, 8'h00, '0, r);
      `CHK(r, {24'h00_0000, e})
   endtask : st
   task automatic w(input logic [7:0] o, input logic [31:0] v);
      logic [31:0] r;
      i_host_core_model.xfer(1'b1, o, v, r);
   endtask : w
   task automatic report_and_stop;
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      logic [31:0] r;
      repeat (16) @(posedge core_clk);
      #1 rst_b = 1;
      repeat (3) @(posedge core_clk);
      st(8'h81);
      `CHK(irq, 1'b1)
      w(8'h00, 32'h0000_005F);
      st(8'h81);
      w(8'h00, 32'h0000_0080);
      st(8'h01);
      `CHK(irq, 1'b0)
      wd = 1;
      repeat (6) @(posedge core_clk);
      #1 wd = 0;
      st(8'h21);
      w(8'h00, '0);
      st(8'h21);
      xtal = 0;
      w(8'h00, 32'h0000_0020);
      st(8'h00);
      `CHK(irq, 1'b0)
      foreach (offs[i]) begin
         i_host_core_model.xfer(1'b0, offs[i], '0, r);
         `CHK(r, 32'h0000_0000)
         w(offs[i], 32'hA5C3_0F00 + i);
         i_host_core_model.xfer(1'b0, offs[i], '0, r);
         `CHK(r, (offs[i] == 8'h0C) ? '0 : 32'hA5C3_0F00 + i)
      end
      `CHK(ce, 32'hA5C3_0F00)
      `CHK(alt, 32'hA5C3_0F01)
      rst_b = 0;
      repeat (2) @(posedge core_clk);
      #1 rst_b = 1;
      repeat (3) @(posedge core_clk);
      `CHK(ce, 32'h0000_0000)
      st(8'h80);
      report_and_stop();
   end
endmodule : battery_backed_register_bank_tb
